// >>> core/dtcs_adc_integrator.v
// integrating serial converter front end model for one channel at a time
`timescale 1ns/1ps
`include "dtcs_defs.vh"

module dtcs_adc_integrator #(
	parameter ADC_W = `DTCS_ADC_W,
	parameter INT_CYC = `DTCS_CHAN_CYC
) (
	input wire ref_clk,
	input wire resetn,
	input wire start,
	input wire bit_in,
	output reg done_ff,
	output reg [ADC_W-1:0] code_ff
);

// ********************
// averaging integrator
// ********************
// counts ones on the serial stream over the whole window; the top bits are the average
reg [31:0] cnt_ff;
reg [31:0] acc_ff;
reg run_ff;
reg [31:0] nxt_cnt;
reg [31:0] nxt_acc;
reg [63:0] scaled;

always @* begin
	nxt_cnt = cnt_ff;
	nxt_acc = acc_ff;
	scaled = 64'h0000_0000_0000_0000;
	if (start) begin
		nxt_cnt = 32'h0000_0000;
		nxt_acc = 32'h0000_0000;
	end else if (run_ff) begin
		nxt_cnt = cnt_ff + 32'h0000_0001;
		nxt_acc = acc_ff + {31'h0000_0000, bit_in};
	end
	// nxt_acc, so the sample taken on the closing edge counts as well
	scaled = ({32'h0000_0000, nxt_acc} << ADC_W) / INT_CYC;
end

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		cnt_ff <= 32'h0000_0000;
		acc_ff <= 32'h0000_0000;
		run_ff <= 1'b0;
		done_ff <= 1'b0;
		code_ff <= {ADC_W{1'b0}};
	end else begin
		cnt_ff <= nxt_cnt;
		acc_ff <= nxt_acc;
		done_ff <= 1'b0;
		if (start) begin
			run_ff <= 1'b1;
		end else if (run_ff && cnt_ff == INT_CYC - 1) begin // R2
			run_ff <= 1'b0;
			done_ff <= 1'b1;
			code_ff <= (scaled[ADC_W] ? {ADC_W{1'b1}} : scaled[ADC_W-1:0]); // R8
		end
	end
end

endmodule // dtcs_adc_integrator

// >>> core/dtcs_sequencer.v
// two channel conversion sequencer with limit compare and status byte
// ********************
// Overview of operation
// R1 - once started, both channels convert automatically with no per-channel command
// R2 - each channel integrates for a sixty millisecond window before its result
// R3 - both channels are always measured, attached sensor or not
// R4 - start command or auto start converts both; results appear at cycle end
// R5 - busy status bit is high exactly while a conversion runs
// R6 - old results stay readable and unchanged until the new cycle completes
// R7 - two result registers, each compared with high and low limit registers
// R8 - core is a twelve bit serial converter muxed across the sensing diodes
// R9 - results are signed two's complement bytes, one degree per bit
// R10 - a full two channel cycle takes about 125 milliseconds
// R11 - run/stop set gives standby: no auto conversions, data kept
// R12 - one-shot command still runs one cycle while in standby
// R13 - a result beyond its high or low limit sets an alarm flag
// R14 - start during a running cycle is ignored; results update once per cycle
// ********************
`timescale 1ns/1ps
`include "dtcs_defs.vh"

module dtcs_sequencer #(
	parameter CHAN_CYC = `DTCS_CHAN_CYC,
	parameter CONV_CYC = `DTCS_CONV_CYC,
	parameter ADC_W = `DTCS_ADC_W
) (
	input wire ref_clk,
	input wire resetn,
	input wire start_cmd,
	input wire run_stop,
	input wire alarm_clear,
	input wire [7:0] limit_hi1,
	input wire [7:0] limit_lo1,
	input wire [7:0] limit_hi2,
	input wire [7:0] limit_lo2,
	input wire sense_channel_one_input,
	input wire sense_channel_two_input,
	output reg sense_channel_one_bias_ff,
	output reg sense_channel_two_bias_ff,
	output reg [7:0] result1_ff,
	output reg [7:0] result2_ff,
	output reg [7:0] status_ff,
	output reg conv_done_ff
);

// ********************
// pin synchronisers
// ********************
reg [1:0] s1_ff;
reg [1:0] s2_ff;
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		s1_ff <= 2'h0;
		s2_ff <= 2'h0;
	end else begin
		s1_ff <= {s1_ff[0], sense_channel_one_input};
		s2_ff <= {s2_ff[0], sense_channel_two_input};
	end
end

// ********************
// state machine
// ********************
localparam ST_IDLE = 4'b0001;
localparam ST_CH1 = 4'b0010;
localparam ST_CH2 = 4'b0100;
localparam ST_WAIT = 4'b1000;

reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [31:0] tmr_ff;
reg [7:0] hold1_ff;
reg [7:0] hold2_ff;
reg adc_start;
wire adc_done;
wire [ADC_W-1:0] adc_code;
wire adc_bit;
wire go;
wire [7:0] temp_now;

// standby only blocks the automatic start; one-shot always wins
assign go = start_cmd | ~run_stop; // R4 R11 R12
// mux steers the converter to the channel under bias
assign adc_bit = state_ff[2] ? s2_ff[1] : s1_ff[1]; // R8
// top byte of the code as signed degrees; front end scales to 1 C per lsb
assign temp_now = adc_code[ADC_W-1:ADC_W-8]; // R9

dtcs_adc_integrator #(
	.ADC_W(ADC_W),
	.INT_CYC(CHAN_CYC)
) u_adc (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.start(adc_start),
	.bit_in(adc_bit),
	.done_ff(adc_done),
	.code_ff(adc_code)
);

always @* begin
	nxt_state = state_ff;
	adc_start = 1'b0;
	case (state_ff)
		ST_IDLE: begin
			if (go) begin // R4
				nxt_state = ST_CH1;
				adc_start = 1'b1;
			end
		end
		ST_CH1: begin
			if (adc_done) begin // R1 R3
				nxt_state = ST_CH2;
				adc_start = 1'b1;
			end
		end
		ST_CH2: begin
			if (adc_done) begin
				nxt_state = ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (tmr_ff >= CONV_CYC - 1) begin // R10
				nxt_state = ST_IDLE;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
		end
	endcase
end

// ********************
// cycle end and timer
// ********************
wire done_cycle;
wire ch1_end;
wire ch2_end;
// the wait state pads every cycle to one length, as long as both windows end inside CONV_CYC
assign done_cycle = state_ff[3] & (tmr_ff >= CONV_CYC - 1); // R10
assign ch1_end = state_ff[1] & adc_done;
assign ch2_end = state_ff[2] & adc_done;

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		state_ff <= ST_IDLE;
		tmr_ff <= 32'h0000_0000;
		conv_done_ff <= 1'b0;
	end else begin
		// start_cmd is only looked at in idle, so a running cycle is untouched
		state_ff <= nxt_state; // R14
		tmr_ff <= (state_ff == ST_IDLE) ? 32'h0000_0000 : tmr_ff + 32'h0000_0001;
		conv_done_ff <= done_cycle;
	end
end

// ********************
// diode bias steering
// ********************
// bias follows the next state so it stands before the first sample of a window
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		sense_channel_one_bias_ff <= 1'b0;
		sense_channel_two_bias_ff <= 1'b0;
	end else begin
		sense_channel_one_bias_ff <= (nxt_state == ST_CH1); // R8
		sense_channel_two_bias_ff <= (nxt_state == ST_CH2); // R3
	end
end

// ********************
// channel holds
// ********************
// results park here so both registers can move on one edge
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		hold1_ff <= `DTCS_RES_RST;
		hold2_ff <= `DTCS_RES_RST;
	end else begin
		if (ch1_end) begin // R1
			hold1_ff <= temp_now;
		end
		if (ch2_end) begin // R3
			hold2_ff <= temp_now;
		end
	end
end

// ********************
// result registers
// ********************
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		result1_ff <= `DTCS_RES_RST;
		result2_ff <= `DTCS_RES_RST;
	end else if (done_cycle) begin
		// both registers move together, once, at cycle end
		result1_ff <= hold1_ff; // R6 R14
		result2_ff <= hold2_ff; // R6
	end
end

// ********************
// limit compare
// ********************
wire [15:0] hold_pk;
wire [15:0] hi_pk;
wire [15:0] lo_pk;
wire [1:0] over;
wire [1:0] under;
wire [3:0] alarm_hit;
assign hold_pk = {hold2_ff, hold1_ff};
assign hi_pk = {limit_hi2, limit_hi1};
assign lo_pk = {limit_lo2, limit_lo1};
genvar gi;
generate
	for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
		// strict compare: a result equal to a limit raises nothing
		assign over[gi] = $signed(hold_pk[gi*8 +: 8]) > $signed(hi_pk[gi*8 +: 8]); // R7 R13
		assign under[gi] = $signed(hold_pk[gi*8 +: 8]) < $signed(lo_pk[gi*8 +: 8]); // R7 R13
	end
endgenerate
assign alarm_hit = {over[0], under[0], over[1], under[1]};

// ********************
// status byte
// ********************
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		status_ff <= 8'h00;
	end else begin
		status_ff[`DTCS_ST_BUSY] <= (nxt_state != ST_IDLE); // R5
		status_ff[2:0] <= 3'h0;
		// a flag set in the clear cycle wins, so no crossing is lost
		status_ff[6:3] <= (alarm_clear ? 4'h0 : status_ff[6:3]) | (done_cycle ? alarm_hit : 4'h0); // R13
	end
end

endmodule // dtcs_sequencer

// >>> shared/dtcs_defs.vh
// constants for the dual channel temperature conversion sequencer
`ifndef DTCS_DEFS_VH
`define DTCS_DEFS_VH

// ********************
// timing
// ********************
`define DTCS_CLK_MHZ 100
`define DTCS_CHAN_MS 60
`define DTCS_CONV_MS 125
`define DTCS_CHAN_CYC (`DTCS_CHAN_MS * 1000 * `DTCS_CLK_MHZ)
`define DTCS_CONV_CYC (`DTCS_CONV_MS * 1000 * `DTCS_CLK_MHZ)

// ********************
// widths and reset values
// ********************
`define DTCS_ADC_W 12
`define DTCS_TEMP_W 8
`define DTCS_RES_RST 8'h00
`define DTCS_HI_RST 8'h7F
`define DTCS_LO_RST 8'h80

// ********************
// status byte fields
// ********************
`define DTCS_ST_BUSY 7
`define DTCS_ST_HI1 6
`define DTCS_ST_LO1 5
`define DTCS_ST_HI2 4
`define DTCS_ST_LO2 3

`endif

// >>> tb/dtcs_afe_model.sv
// front end model: one steady bitstream per sensing diode
`timescale 1ns/1ps
module dtcs_afe (
	input wire ref_clk,
	input wire lvl1,
	input wire lvl2,
	output reg bit1,
	output reg bit2
);
	// launched off the edge, the sequencer syncs it anyway
	always @(posedge ref_clk) begin
		bit1 <= lvl1;
		bit2 <= lvl2;
	end
endmodule // dtcs_afe

// >>> tb/dtcs_assertions.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
module dtcs_chk #(
	parameter CHAN_CYC = 20,
	parameter CONV_CYC = 60
) (
	input wire ref_clk,
	input wire resetn,
	input wire start_cmd,
	input wire run_stop,
	input wire sense_channel_one_bias_ff,
	input wire sense_channel_two_bias_ff,
	input wire [7:0] result1_ff,
	input wire [7:0] result2_ff,
	input wire [7:0] status_ff,
	input wire conv_done_ff
);
	localparam int LO = 2 * CHAN_CYC;
	localparam int HI = CONV_CYC + 4;
	wire busy = status_ff[7];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_keep; !conv_done_ff |-> $stable(result1_ff) && $stable(result2_ff); endproperty
	a_keep: assert property (p_keep) else $error("results moved outside done");
	property p_start; !busy && start_cmd |=> busy; endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_auto; !busy && !run_stop |=> busy; endproperty
	a_auto: assert property (p_auto) else $error("no auto start");
	property p_idle; !busy && run_stop && !start_cmd |=> !busy; endproperty
	a_idle: assert property (p_idle) else $error("start in standby");
	property p_end; conv_done_ff |-> !busy ##1 !conv_done_ff; endproperty
	a_end: assert property (p_end) else $error("busy or done wrong at end");
	property p_excl; !(sense_channel_one_bias_ff && sense_channel_two_bias_ff); endproperty
	a_excl: assert property (p_excl) else $error("both diodes biased");
	property p_bias; sense_channel_one_bias_ff || sense_channel_two_bias_ff |-> busy; endproperty
	a_bias: assert property (p_bias) else $error("bias while idle");
	property p_len; $rose(busy) |-> ##[LO:HI] conv_done_ff; endproperty
	a_len: assert property (p_len) else $error("cycle length wrong");
	property p_first; $rose(busy) |-> sense_channel_one_bias_ff; endproperty
	a_first: assert property (p_first) else $error("channel one not first");
	c_single: cover property (start_cmd && !busy);
	c_auto: cover property (!run_stop && $rose(busy));
	c_alarm: cover property (conv_done_ff && status_ff[5]);
endmodule // dtcs_chk
bind dtcs_sequencer dtcs_chk #(.CHAN_CYC(CHAN_CYC), .CONV_CYC(CONV_CYC)) u_chk (.ref_clk,
	.resetn, .start_cmd, .run_stop, .sense_channel_one_bias_ff, .sense_channel_two_bias_ff,
	.result1_ff, .result2_ff, .status_ff, .conv_done_ff);

// >>> tb/dtcs_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module dtcs_tb_top;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic start_cmd = 1'b0;
	logic run_stop = 1'b1;
	logic alarm_clear = 1'b0;
	logic lvl1 = 1'b1;
	logic lvl2 = 1'b0;
	logic [7:0] lim_hi1 = 8'h7f;
	logic [7:0] lim_lo1 = 8'h00;
	logic [7:0] lim_hi2 = 8'hff;
	logic [7:0] lim_lo2 = 8'h80;
	wire b1, b2, s1, s2, done;
	wire [7:0] r1, r2, st;
	int bad_count = 0;
	int checks = 0;
	always #5 ref_clk = ~ref_clk;
	dtcs_afe u_afe (.ref_clk(ref_clk), .lvl1(lvl1), .lvl2(lvl2), .bit1(s1), .bit2(s2));
	dtcs_sequencer #(.CHAN_CYC(20), .CONV_CYC(60)) DUT (.ref_clk(ref_clk), .resetn(resetn),
		.start_cmd(start_cmd), .run_stop(run_stop), .alarm_clear(alarm_clear),
		.limit_hi1(lim_hi1), .limit_lo1(lim_lo1), .limit_hi2(lim_hi2), .limit_lo2(lim_lo2),
		.sense_channel_one_input(s1), .sense_channel_two_input(s2),
		.sense_channel_one_bias_ff(b1), .sense_channel_two_bias_ff(b2),
		.result1_ff(r1), .result2_ff(r2), .status_ff(st), .conv_done_ff(done));
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_done;
		int i;
		i = 0;
		while (done !== 1'b1 && i < 200) begin
			tick(1);
			i++;
		end
		`CK("done", 1'b1, done)
	endtask
	// one shot in standby, with a restart that must be ignored
	task automatic t_single;
		start_cmd = 1'b1;
		tick(1);
		start_cmd = 1'b0;
		`CK("busy", 1'b1, st[7])
		`CK("bias", 2'b10, {b1, b2})
		tick(10);
		start_cmd = 1'b1;
		tick(1);
		start_cmd = 1'b0;
		wait_done;
		`CK("res1", 8'hff, r1)
		`CK("res2", 8'h00, r2)
		`CK("stat", 8'h30, st)
		tick(20);
		`CK("idle", 8'h30, st)
	endtask
	task automatic t_clear;
		alarm_clear = 1'b1;
		tick(1);
		alarm_clear = 1'b0;
		`CK("clear", 8'h00, st)
	endtask
	// free running, back to back cycles, then standby again
	task automatic t_free;
		lvl1 = 1'b0;
		lvl2 = 1'b1;
		tick(6);
		run_stop = 1'b0;
		tick(1);
		`CK("auto", 1'b1, st[7])
		`CK("keep", 8'hff, r1)
		wait_done;
		`CK("res1b", 8'h00, r1)
		`CK("res2b", 8'hff, r2)
		`CK("noalm", 8'h00, st)
		`CK("gap", 1'b0, st[7])
		tick(1);
		`CK("again", 1'b1, st[7])
		lim_hi1 = 8'h80;
		wait_done;
		`CK("hi1", 8'h40, st)
		run_stop = 1'b1;
		tick(3);
		`CK("stop", 1'b0, st[7])
	endtask
	task automatic test_done;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		tick(2);
		resetn = 1'b1;
		tick(1);
		t_single;
		t_clear;
		t_free;
		test_done;
	end
	initial begin
		#50000;
		bad_count++;
		test_done;
	end
endmodule // dtcs_tb_top
